// file: sacs_pkg.sv
// Package for the serial converter control sequencer: constants and types
// Contract
// - Chip select high: output floats, inputs ignored
// - Accept low select after two rises, one fall
// - Previous result MSB appears at recognition
// - Four address bits captured MSB first
// - First four falls shift out bits two-five
// - After fourth fall, select channel, start sampling
// - Three more falls shift out bits six-eight
// - Eighth fall holds, converts 36 system cycles
// - Recognized select fall resets, aborts conversion
// - New full sequence aborts, restarts conversion
// - Select low across conversions counts every edge
// - Conversion and shift clocks are independent
// - Shared clock: first two cycles only recognize
// - Shared clock: uses it to convert when deselected
// - Address 1011 selects self-test source
package sacs_pkg;
    localparam logic [5:0] SACS_CONV_CYCLES = 6'h24;
    localparam logic [3:0] SACS_BITS = 4'h8;
    localparam logic [3:0] SACS_SAMPLE_AT = 4'h4;
    localparam logic [3:0] SACS_SELF_TEST_CHANNEL = 4'hB;
    localparam logic [7:0] SACS_RESULT_RESET = 8'h00;

    typedef enum logic [1:0] {
        SACS_IDLE = 2'b00,
        SACS_WAIT = 2'b01,
        SACS_XFER = 2'b10
    } sacs_phase_t;

    typedef struct packed {
        logic [1:0] cs_s;
        logic [1:0] io_s;
        logic [1:0] sys_s;
        logic [1:0] addr_s;
        logic io_prev;
        logic sys_prev;
    } sacs_sync_t;

    typedef struct packed {
        sacs_sync_t sync;
        sacs_phase_t phase;
        logic [1:0] rise_cnt;
        logic [3:0] edge_cnt;
        logic [3:0] addr;
        logic [3:0] channel;
        logic [7:0] shifter;
        logic [7:0] result;
        logic [7:0] sar;
        logic [5:0] conv_cnt;
        logic converting;
        logic sampling;
        logic dout;
        logic dout_oe;
    } sacs_state_t;
endpackage

// file: sacs_control.sv
// Control sequencer of a serial 8-bit successive-approximation converter
`timescale 1ns/1ps
`default_nettype none
module sacs_control
    import sacs_pkg::*;
(
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RST,
    // Serial pins from the host
    input wire logic CS_N,
    input wire logic IO_CLK,
    input wire logic SYS_CLK,
    input wire logic ADDR_IN,
    // Serial result pin
    output logic DATA_OUT,
    output logic DATA_OUT_OE,
    // Analog front end
    input wire logic COMPARE_IN,
    output logic [3:0] CHANNEL,
    output logic SAMPLING,
    output logic [7:0] TRIAL_CODE,
    output logic CONVERTING
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    sacs_state_t s_q;
    sacs_state_t s_d;
    logic cs_low;
    logic io_rise;
    logic io_fall;
    logic sys_rise;
    logic sys_fall;

    // Edges read only from the second synchroniser stage
    assign cs_low = ~s_q.sync.cs_s[1];
    assign io_rise = s_q.sync.io_s[1] & ~s_q.sync.io_prev;
    assign io_fall = ~s_q.sync.io_s[1] & s_q.sync.io_prev;
    assign sys_rise = s_q.sync.sys_s[1] & ~s_q.sync.sys_prev;
    assign sys_fall = ~s_q.sync.sys_s[1] & s_q.sync.sys_prev;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        s_d = s_q;
        s_d.sync.cs_s = {s_q.sync.cs_s[0], CS_N};
        s_d.sync.io_s = {s_q.sync.io_s[0], IO_CLK};
        s_d.sync.sys_s = {s_q.sync.sys_s[0], SYS_CLK};
        s_d.sync.addr_s = {s_q.sync.addr_s[0], ADDR_IN};
        s_d.sync.io_prev = s_q.sync.io_s[1];
        s_d.sync.sys_prev = s_q.sync.sys_s[1];
        // Conversion runs on system clock only; io clock plays no part
        if (s_q.converting && sys_rise)
        begin
            // Shared-clock mode needs nothing extra: conversion just counts SYS edges
            s_d.conv_cnt = s_q.conv_cnt + 6'h01;
            // One trial bit per cycle for the first eight cycles
            if (s_q.conv_cnt < 6'(SACS_BITS))
            begin
                s_d.sar[3'(3'd7 - s_q.conv_cnt[2:0])] = COMPARE_IN;
                if (s_q.conv_cnt < 6'(SACS_BITS - 4'h1))
                    s_d.sar[3'(3'd6 - s_q.conv_cnt[2:0])] = 1'b1;
            end
            if (s_q.conv_cnt == SACS_CONV_CYCLES - 6'h01)
            begin
                s_d.converting = 1'b0;
                s_d.result = s_d.sar;
                // Select held low: the next transfer must show this fresh result
                if (s_q.phase == SACS_XFER && s_q.edge_cnt == 4'h0)
                begin
                    s_d.shifter = s_d.sar;
                    s_d.dout = s_d.sar[7];
                end
            end
        end
        case (s_q.phase)
            SACS_IDLE:
            begin
                s_d.dout_oe = 1'b0;
                s_d.rise_cnt = 2'b00;
                if (cs_low)
                    s_d.phase = SACS_WAIT;
            end
            SACS_WAIT:
            begin
                // Glitch filter: two rises then a fall, select still low
                if (!cs_low)
                    s_d.phase = SACS_IDLE;
                // Shared clock: the filter swallows its first two cycles
                else if (sys_rise && s_q.rise_cnt != 2'b10)
                    s_d.rise_cnt = s_q.rise_cnt + 2'b01;
                else if (sys_fall && s_q.rise_cnt == 2'b10)
                begin
                    s_d.phase = SACS_XFER;
                    s_d.edge_cnt = 4'h0;
                    s_d.converting = 1'b0;
                    s_d.sampling = 1'b0;
                    s_d.shifter = s_q.result;
                    s_d.dout = s_q.result[7];
                    s_d.dout_oe = 1'b1;
                end
            end
            SACS_XFER:
            begin
                if (!cs_low)
                begin
                    // Conversion left running; only the transfer ends
                    s_d.phase = SACS_IDLE;
                    s_d.dout_oe = 1'b0;
                end
                else
                begin
                    // Every io fall counts while select stays low
                    if (io_rise && s_q.edge_cnt < SACS_SAMPLE_AT)
                        // Address pin delayed like the clock so both line up at the edge
                        s_d.addr = {s_q.addr[2:0], s_q.sync.addr_s[1]};
                    if (io_fall)
                    begin
                        s_d.shifter = {s_q.shifter[6:0], 1'b0};
                        s_d.dout = s_q.shifter[6];
                        s_d.edge_cnt = s_q.edge_cnt + 4'h1;
                        if (s_q.edge_cnt == SACS_SAMPLE_AT - 4'h1)
                        begin
                            // Self-test address routes like any other channel
                            s_d.channel = s_q.addr;
                            s_d.sampling = 1'b1;
                            s_d.converting = 1'b0;
                        end
                        if (s_q.edge_cnt == SACS_BITS - 4'h1)
                        begin
                            // Strobe timing is set by when this fall arrives
                            s_d.sampling = 1'b0;
                            s_d.converting = 1'b1;
                            s_d.conv_cnt = 6'h00;
                            s_d.sar = 8'h80;
                            s_d.edge_cnt = 4'h0;
                            s_d.shifter = s_q.result;
                            s_d.dout = s_q.result[7];
                        end
                    end
                end
            end
            default:
                s_d.phase = SACS_IDLE;
        endcase
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            s_q <= '0;
            s_q.sync.cs_s <= 2'b11;
            s_q.result <= SACS_RESULT_RESET;
            s_q.phase <= SACS_IDLE;
        end
        else
            s_q <= s_d;
    end

    assign DATA_OUT = s_q.dout;
    assign DATA_OUT_OE = s_q.dout_oe;
    assign CHANNEL = s_q.channel;
    assign SAMPLING = s_q.sampling;
    assign TRIAL_CODE = s_q.sar;
    assign CONVERTING = s_q.converting;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence recognized_s;
        s_q.phase == SACS_WAIT && s_d.phase == SACS_XFER;
    endsequence

    output_float_a: assert property (@(posedge CLOCK) disable iff (RST)
        s_q.phase == SACS_IDLE |=> !DATA_OUT_OE)
        else $error("Output driven while deselected");
    recognize_msb_a: assert property (@(posedge CLOCK) disable iff (RST)
        recognized_s |=> DATA_OUT_OE && DATA_OUT == $past(s_q.result[7]))
        else $error("MSB not presented at recognition");
    filter_rises_a: assert property (@(posedge CLOCK) disable iff (RST)
        recognized_s |-> s_q.rise_cnt == 2'b10 && cs_low)
        else $error("Select recognized without two rises");
    sample_start_a: assert property (@(posedge CLOCK) disable iff (RST)
        s_q.phase == SACS_XFER && cs_low && io_fall && s_q.edge_cnt == 4'h3
        |=> SAMPLING && CHANNEL == $past(s_q.addr))
        else $error("Sampling not started after fourth fall");
    hold_start_a: assert property (@(posedge CLOCK) disable iff (RST)
        s_q.phase == SACS_XFER && cs_low && io_fall && s_q.edge_cnt == 4'h7
        |=> CONVERTING && !SAMPLING && s_q.conv_cnt == 6'h00)
        else $error("Hold not started at eighth fall");
    conv_length_a: assert property (@(posedge CLOCK) disable iff (RST)
        CONVERTING |-> s_q.conv_cnt < SACS_CONV_CYCLES)
        else $error("Conversion ran past its cycle count");
    abort_a: assert property (@(posedge CLOCK) disable iff (RST)
        recognized_s |=> !CONVERTING)
        else $error("Conversion not aborted on recognition");
    result_keep_a: assert property (@(posedge CLOCK) disable iff (RST)
        !(s_q.converting && sys_rise && s_q.conv_cnt == SACS_CONV_CYCLES - 6'h01)
        |=> s_q.result == $past(s_q.result))
        else $error("Result changed without finished conversion");

    sequence fall_in_xfer_s;
        s_q.phase == SACS_XFER && cs_low && io_fall;
    endsequence
    addr_ignore_a: assert property (@(posedge CLOCK) disable iff (RST)
        s_q.phase != SACS_XFER |=> s_q.addr == $past(s_q.addr))
        else $error("Address shifted before recognition");
    deselect_float_a: assert property (@(posedge CLOCK) disable iff (RST)
        !cs_low |=> !DATA_OUT_OE)
        else $error("Output still driven after deselect");
    shift_out_a: assert property (@(posedge CLOCK) disable iff (RST)
        fall_in_xfer_s ##0 s_q.edge_cnt != 4'h7 |=> DATA_OUT == $past(s_q.shifter[6]))
        else $error("Result bit not shifted on fall");
endmodule // sacs_control
`default_nettype wire

// file: sacs_host.sv
// Host model driving select, shift clock and address pins
`timescale 1ns/1ps
`default_nettype none
module sacs_host
(
    // Clock
    input wire logic clk,
    // Serial pins
    input wire logic data_out,
    input wire logic data_oe,
    output var logic cs_n,
    output var logic io_clk,
    output var logic addr_in
);
    // ----------
    // Transfers
    // ----------
    initial
    begin
        cs_n = 1'b1;
        io_clk = 1'b0;
        addr_in = 1'b0;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Eight shift cycles, previous result comes back MSB first
    task automatic xfer(input logic [3:0] addr, output logic [7:0] res, output logic ok);
        int w;
        w = 0;
        hold(1);
        cs_n = 1'b0;
        while (data_oe !== 1'b1 && w < 40)
        begin
            hold(1);
            w++;
        end
        ok = (w < 40);
        hold(2);
        for (int i = 0; i < 8; i++)
        begin
            addr_in = (i < 4) ? addr[3 - i] : ~addr_in;
            hold(4);
            io_clk = 1'b1;
            hold(4); // Sample late so the last fall has settled
            res[7 - i] = data_out;
            io_clk = 1'b0;
        end
    endtask
    // Deselect and leave the clock low while converting
    task automatic deselect(input int n);
        hold(1);
        cs_n = 1'b1;
        addr_in = ~addr_in;
        hold(n);
    endtask
    // Short select glitch, shift clock wiggling while deselected
    task automatic noise();
        hold(1);
        cs_n = 1'b0;
        hold(1);
        cs_n = 1'b1;
        clocks(3);
    endtask
    // Free clock pulses; with select high in shared mode they run the conversion
    task automatic clocks(input int n);
        repeat (n)
        begin
            io_clk = 1'b1;
            hold(4);
            io_clk = 1'b0;
            hold(4);
        end
    endtask
    // Shared clock: two recognition clocks, eight shift clocks, then deselect
    task automatic xfer_shared(input logic [3:0] addr, output logic [7:0] res);
        hold(1);
        cs_n = 1'b0;
        hold(4);
        for (int i = 0; i < 10; i++)
        begin
            io_clk = 1'b1;
            hold(4);
            if (i >= 2)
                res[9 - i] = data_out;
            io_clk = 1'b0;
            if (i >= 1 && i < 5)
                addr_in = addr[4 - i];
            hold(4);
        end
        cs_n = 1'b1;
    endtask
endmodule // sacs_host
`default_nettype wire

// file: tb.sv
// Self-checking bench of the converter control sequencer
`timescale 1ns/1ps
`default_nettype none
module tb
    import sacs_pkg::*;
;
    logic clock, rst, cs_n, io_clk, sys_clk, addr_in, data_out, data_oe;
    logic compare_in, sampling, converting, ok, shared;
    logic [3:0] channel;
    logic [7:0] trial_code, target, done_res, res;
    int fails, checked, cycles;
    integer seed;
    sacs_control sacs_control_i (.CLOCK(clock), .RST(rst), .CS_N(cs_n), .IO_CLK(io_clk),
        .SYS_CLK(shared ? io_clk : sys_clk), .ADDR_IN(addr_in), .DATA_OUT(data_out),
        .DATA_OUT_OE(data_oe), .COMPARE_IN(compare_in), .CHANNEL(channel), .SAMPLING(sampling),
        .TRIAL_CODE(trial_code), .CONVERTING(converting));
    sacs_host sacs_host_i (.clk(clock), .data_out(data_out), .data_oe(data_oe),
        .cs_n(cs_n), .io_clk(io_clk), .addr_in(addr_in));
    // ----------
    // Clocks, comparator and timeout
    // ----------
    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    // Conversion clock free-running, unrelated to the shift clock
    always
    begin
        repeat (3) @(posedge clock);
        #1 sys_clk = ~sys_clk;
    end
    always @(posedge clock) #1 compare_in = (trial_code <= target);
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fails++;
            finish_test();
        end
    end
    // ----------
    // Checks
    // ----------
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic frame(input logic [3:0] addr, input logic [7:0] tgt, input bit wait_done);
        target = tgt;
        sacs_host_i.xfer(addr, res, ok);
        check("recognized", {7'h00, ok}, 8'h01);
        check("result", res, done_res);
        check("channel", {4'h0, channel}, {4'h0, addr});
        if (wait_done)
        begin
            sacs_host_i.deselect(6);
            check("converting", {7'h00, converting}, 8'h01);
            check("out_enable", {7'h00, data_oe}, 8'h00);
            sacs_host_i.hold(190);
            check("conv_busy", {7'h00, converting}, 8'h01);
            sacs_host_i.hold(40);
            check("conv_done", {7'h00, converting}, 8'h00);
            done_res = tgt;
        end
    endtask
    task automatic finish_test();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ----------
    // Sequence
    // ----------
    initial
    begin
        seed = 32'hae0d;
        rst = 1'b1;
        sys_clk = 1'b0;
        shared = 1'b0;
        compare_in = 1'b0;
        target = 8'h00;
        done_res = SACS_RESULT_RESET;
        repeat (12) @(posedge clock);
        #1 rst = 1'b0;
        check("reset_oe", {7'h00, data_oe}, 8'h00);
        check("reset_chan", {4'h0, channel}, 8'h00);
        check("reset_busy", {6'h00, sampling, converting}, 8'h00);
        $display("test reset done");
        for (int i = 0; i < 12; i++)
            frame(i[3:0], 8'($random(seed)), 1'b1);
        frame(SACS_SELF_TEST_CHANNEL, 8'h80, 1'b1);
        $display("test channels done");
        frame(4'h3, 8'($random(seed)), 1'b0);
        frame(4'h5, 8'($random(seed)), 1'b1);
        frame(4'h2, 8'($random(seed)), 1'b1);
        $display("test abort done");
        sacs_host_i.noise();
        check("glitch_oe", {7'h00, data_oe}, 8'h00);
        check("glitch_chan", {4'h0, channel}, 8'h02);
        frame(4'h7, 8'($random(seed)), 1'b1);
        $display("test glitch done");
        frame(4'h6, 8'($random(seed)), 1'b0);
        sacs_host_i.hold(240);
        check("low_done", {7'h00, converting}, 8'h00);
        done_res = target;
        frame(4'h4, 8'($random(seed)), 1'b1);
        $display("test select held low done");
        shared = 1'b1;
        target = 8'($random(seed));
        sacs_host_i.xfer_shared(4'h9, res);
        check("shared_result", res, done_res);
        check("shared_chan", {4'h0, channel}, 8'h09);
        check("shared_busy", {7'h00, converting}, 8'h01);
        sacs_host_i.clocks(40);
        check("shared_done", {7'h00, converting}, 8'h00);
        done_res = target;
        shared = 1'b0;
        frame(4'h1, 8'($random(seed)), 1'b1);
        $display("test shared clock done");
        finish_test();
    end
endmodule // tb
`default_nettype wire
